// ---- pnp_mode_pin_steering.sv ----
// Mode-dependent pin steering for a single logical device ISA front end.
// Assumes all pins are synchronous to core_clk and the configuration word
// arrives from the non-volatile store with a one-cycle load strobe.
//
// What this block does
// - Two-bit mode: 00 is DMA mode, 01 extended interrupt mode; pins follow it.
// - Mode comes from configuration stored in non-volatile memory, never a pin.
// - Shared input is on-board DMA request, or ISA address bit 15.
// - Shared low output is DMA acknowledge, or the third chip select.
// - Two shared outputs are ISA DMA requests, or interrupt outputs 6 and 7.
// - Two shared low inputs are ISA DMA acknowledges, or address bits 12, 13.
// - Shared input is second board interrupt, or ISA address bit 14.
// - Each board interrupt routes onto any of six base ISA interrupt lines.
// - Two always-present low chip selects assert on their programmed address.
// - Serial read data leaves on the dedicated data output.
// - State machines run from the bus oscillator, up to 24 MHz.
// - Bus reset returns all logic but the store array to its reset state.
// - Names marked active low are asserted when low, on both sides.
// - Address enable qualifies I/O decoding against DMA cycles.
// - Each chip select decodes on address alone or address plus command.
// - In DMA mode the board DMA request goes to either ISA channel.
`timescale 1ns/10ps
`default_nettype none
`include "pms_map.svh"

module pnp_mode_pin_steering #(
    parameter int EE_WORDS = `PMS_EE_WORDS,
    parameter int EE_AW    = `PMS_EE_AW,
    parameter int EE_DW    = `PMS_EE_DW
)
(
    // Clock and reset from the bus
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    // Configuration from the non-volatile store
    input  wire pms_pkg::pms_cfg_t     nv_cfg,
    input  wire logic                  nv_cfg_load,
    // ISA I/O cycle
    input  wire logic [11:0]           isa_addr,
    input  wire logic                  io_rd_n,
    input  wire logic                  io_wr_n,
    input  wire logic                  addr_en,
    // Shared inputs
    input  wire logic                  board_dma_req_in,
    input  wire logic [1:0]            board_irq_in,
    input  wire logic [1:0]            host_dma_ack_n,
    // Steered outputs
    output logic [5:0]                 irq_steer_out,
    output logic [1:0]                 host_dma_req,
    output logic                       board_dma_ack_n,
    output logic [1:0]                 prog_chip_sel_n,
    // Serial store port
    input  wire logic                  ee_cs,
    input  wire logic                  ee_sk,
    input  wire logic                  ee_di,
    output logic                       ee_do
);

    // True when route r drives ISA line n
    function automatic logic route_hit(input pms_pkg::pms_irq_route_t r,
                                       input logic req, input logic [2:0] n);
        route_hit = req && r.en && (r.line == n);
    endfunction

    // Configuration register; reset state is DMA mode with everything off
    pms_pkg::pms_cfg_t cfg_q;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            cfg_q <= `PMS_CFG_RST;
        else if (nv_cfg_load)
            cfg_q <= nv_cfg;
    end

    // Reserved codes keep DMA roles, so only 01 switches the pins
    wire ext_mode = (cfg_q.mode == `PMS_MODE_EXT);

    // Shared pins become upper address bits only in extended mode
    wire [3:0] addr_hi = ext_mode ? {board_dma_req_in, board_irq_in[1],
                                     host_dma_ack_n} : 4'h0;
    wire       irq1_in = ext_mode ? 1'b0 : board_irq_in[1];
    wire pms_pkg::pms_isa_cyc_t cyc = '{addr: {addr_hi, isa_addr},
                                        rd:   !io_rd_n,
                                        wr:   !io_wr_n,
                                        aen:  addr_en};

    // Chip select decoders; the third drives a pin only in extended mode
    wire [2:0] cs_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_cs
            pms_cs_decode u_dec
            (
                .cfg (cfg_q.cs[gi]),
                .cyc (cyc),
                .hit (cs_hit[gi])
            );
        end
    endgenerate

    // Interrupt crossbar over eight ISA lines; lines 6 and 7 need extended mode
    wire [7:0] irq_vec;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_irq
            assign irq_vec[gi] = ((gi < 6) || ext_mode) &&
                (route_hit(cfg_q.irq[0], board_irq_in[0], 3'(gi)) ||
                 route_hit(cfg_q.irq[1], irq1_in, 3'(gi)));
        end
    endgenerate

    // DMA steering: one board request onto the chosen ISA channel
    wire       dma_req  = cfg_q.dma_en && board_dma_req_in;
    wire [1:0] drq_dma  = dma_req ? (cfg_q.dma_chan ? 2'h2 : 2'h1) : 2'h0;
    wire       dack_hit = cfg_q.dma_en && !host_dma_ack_n[cfg_q.dma_chan];

    // Next pin values
    wire [1:0] drq_d  = ext_mode ? irq_vec[7:6] : drq_dma;
    wire       dack_d = ext_mode ? !cs_hit[2] : !dack_hit;

    // Output registers; all pins idle inactive under reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_steer_out   <= 6'h00;
            host_dma_req    <= 2'h0;
            board_dma_ack_n <= 1'h1;
            prog_chip_sel_n <= 2'h3;
        end
        else
        begin
            irq_steer_out   <= irq_vec[5:0];
            host_dma_req    <= drq_d;
            board_dma_ack_n <= dack_d;
            prog_chip_sel_n <= ~cs_hit[1:0];
        end
    end

    // Serial port: inputs are synchronous, so a plain edge detect suffices
    logic                  sk_q;
    pms_pkg::pms_sp_state_t sp_q;
    logic [1:0]            op_q;
    logic [EE_AW-1:0]      adr_q;
    logic [EE_DW-1:0]      sh_q;
    logic [3:0]            cnt_q;
    logic [EE_DW-1:0]      mem [0:EE_WORDS-1];

    wire sk_rise  = ee_sk && !sk_q;
    wire cnt_last = (cnt_q == 4'(EE_DW - 1));
    wire adr_last = (cnt_q == 4'(EE_AW - 1));
    wire op_last  = (cnt_q == `PMS_OP_BITS - 4'h1);
    wire [EE_AW-1:0] adr_nx = {adr_q[EE_AW-2:0], ee_di};
    wire [EE_DW-1:0] wd_nx  = {sh_q[EE_DW-2:0], ee_di};
    // Select must still stand at the 16th rise, so a cut frame writes nothing
    wire wr_fire  = ee_cs && (sp_q == pms_pkg::PMS_SP_WDATA) && sk_rise && cnt_last;

    // Sequencer: start bit, opcode, address, then data in or out.
    // Dropping the select aborts at once, so an unused port tied low idles.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sk_q  <= 1'h0;
            sp_q  <= pms_pkg::PMS_SP_IDLE;
            op_q  <= 2'h0;
            adr_q <= '0;
            sh_q  <= '0;
            cnt_q <= 4'h0;
            ee_do <= 1'h0;
        end
        else
        begin
            sk_q <= ee_sk;
            if (!ee_cs)
            begin
                sp_q  <= pms_pkg::PMS_SP_IDLE;
                cnt_q <= 4'h0;
                ee_do <= 1'h0;
            end
            else if (sk_rise)
            begin
                cnt_q <= cnt_q + 4'h1;
                case (sp_q)
                    pms_pkg::PMS_SP_IDLE:
                    begin
                        cnt_q <= 4'h0;
                        if (ee_di)
                            sp_q <= pms_pkg::PMS_SP_OP;
                    end
                    pms_pkg::PMS_SP_OP:
                    begin
                        op_q <= {op_q[0], ee_di};
                        if (op_last)
                        begin
                            sp_q  <= pms_pkg::PMS_SP_ADDR;
                            cnt_q <= 4'h0;
                        end
                    end
                    pms_pkg::PMS_SP_ADDR:
                    begin
                        adr_q <= adr_nx;
                        if (adr_last)
                        begin
                            cnt_q <= 4'h0;
                            sh_q  <= mem[adr_nx];
                            if (op_q == `PMS_OP_READ)
                                sp_q <= pms_pkg::PMS_SP_READ;
                            else if (op_q == `PMS_OP_WRITE)
                                sp_q <= pms_pkg::PMS_SP_WDATA;
                            else
                                sp_q <= pms_pkg::PMS_SP_DONE;
                        end
                    end
                    pms_pkg::PMS_SP_READ:
                    begin
                        ee_do <= sh_q[EE_DW-1];
                        sh_q  <= {sh_q[EE_DW-2:0], 1'b0};
                        if (cnt_last)
                            sp_q <= pms_pkg::PMS_SP_DONE;
                    end
                    pms_pkg::PMS_SP_WDATA:
                    begin
                        sh_q <= wd_nx;
                        if (cnt_last)
                            sp_q <= pms_pkg::PMS_SP_DONE;
                    end
                    pms_pkg::PMS_SP_DONE:
                        cnt_q <= 4'h0;
                    default:
                        sp_q <= pms_pkg::PMS_SP_IDLE;
                endcase
            end
        end
    end

    // Store array carries no reset; contents are non-volatile by intent
    always_ff @(posedge core_clk)
    begin
        if (wr_fire)
            mem[adr_q] <= wd_nx;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_read_bit;
        (sp_q == pms_pkg::PMS_SP_READ) && ee_cs && sk_rise;
    endsequence
    sequence s_cfg_steady;
        !nv_cfg_load;
    endsequence

    a_mode_from_store: assert property (nv_cfg_load |=> cfg_q == $past(nv_cfg))
        else $error("Configuration not taken from the store");
    a_reserved_mode_dma: assert property (
        cfg_q.mode[1] |=> host_dma_req == $past(drq_dma))
        else $error("Reserved mode left DMA roles");
    a_ext_third_cs: assert property (
        ((ext_mode && cs_hit[2]) and s_cfg_steady) |=> !board_dma_ack_n)
        else $error("Third chip select not driven");
    a_dma_ack_path: assert property (
        ((!ext_mode && dack_hit) and s_cfg_steady) |=> !board_dma_ack_n)
        else $error("Board DMA acknowledge missing");
    a_drq_channel: assert property (
        ((!ext_mode && dma_req) and s_cfg_steady)
        |=> host_dma_req == (cfg_q.dma_chan ? 2'h2 : 2'h1))
        else $error("DMA request on wrong channel");
    a_ext_irq_high: assert property (
        ext_mode |=> host_dma_req == $past(irq_vec[7:6]))
        else $error("Upper interrupts not on shared outputs");
    a_irq_route_0: assert property (
        ((board_irq_in[0] && cfg_q.irq[0].en && cfg_q.irq[0].line < 3'h6) and s_cfg_steady)
        |=> irq_steer_out[$past(cfg_q.irq[0].line)])
        else $error("Board interrupt not steered");
    a_aen_blocks_cs: assert property (addr_en |=> prog_chip_sel_n == 2'h3)
        else $error("Chip select during DMA cycle");
    a_qual_cmd_cs: assert property (
        cfg_q.cs[1].qual_cmd && io_rd_n && io_wr_n |=> prog_chip_sel_n[1])
        else $error("Qualified chip select without command");
    a_read_shift_out: assert property (
        s_read_bit |=> ee_do == $past(sh_q[EE_DW-1]))
        else $error("Serial read bit wrong");
    a_cs_low_idle: assert property (
        !ee_cs |=> sp_q == pms_pkg::PMS_SP_IDLE ##1
        (!ee_cs || sp_q != pms_pkg::PMS_SP_READ))
        else $error("Serial port not idle with select low");

endmodule

`default_nettype wire

// ---- pms_map.svh ----
// Constants for the mode-dependent pin steering block: mode codes,
// configuration reset value, serial port opcodes and clock figures.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// Two-bit operating mode codes
`define PMS_MODE_DMA      2'h0
`define PMS_MODE_EXT      2'h1

// Reset value of the whole configuration word: DMA mode, all routes off
`define PMS_CFG_RST       '0

// Serial port opcodes, sent after the start bit
`define PMS_OP_READ       2'h2
`define PMS_OP_WRITE      2'h1
`define PMS_OP_BITS       4'h2

// Serial port store: 256 words of 16 bits, 4k bits in all
`define PMS_EE_WORDS      256
`define PMS_EE_AW         8
`define PMS_EE_DW         16

// Oscillator figures in kHz; nominal bus oscillator and highest tolerated
`define PMS_OSC_NOM_KHZ   14318
`define PMS_OSC_MAX_KHZ   24000

`endif

// ---- pms_pkg.sv ----
// Types for the mode-dependent pin steering block.
// Assumes pms_map.svh supplies the numeric constants.
package pms_pkg;

    // Routing of one on-board interrupt request onto an ISA line
    typedef struct packed {
        logic       en;
        logic [2:0] line;
    } pms_irq_route_t;

    // One programmable chip select: mask bits are don't-care address bits
    typedef struct packed {
        logic        en;
        logic        qual_cmd;
        logic [15:0] base;
        logic [15:0] mask;
    } pms_cs_cfg_t;

    // Configuration word as held in the non-volatile store
    typedef struct packed {
        logic [1:0]           mode;
        pms_irq_route_t [1:0] irq;
        logic                 dma_en;
        logic                 dma_chan;
        pms_cs_cfg_t [2:0]    cs;
    } pms_cfg_t;

    // One ISA I/O cycle as seen by the chip select decoders
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic        aen;
    } pms_isa_cyc_t;

    // Serial port sequencer states
    typedef enum logic [2:0] {
        PMS_SP_IDLE,
        PMS_SP_OP,
        PMS_SP_ADDR,
        PMS_SP_READ,
        PMS_SP_WDATA,
        PMS_SP_DONE
    } pms_sp_state_t;

endpackage

// ---- pms_cs_decode.sv ----
// One programmable chip select decoder, purely combinational.
// Assumes the caller registers the hit before it reaches a pin.
`timescale 1ns/10ps
`default_nettype none

module pms_cs_decode
(
    // Configuration of this select
    input  wire pms_pkg::pms_cs_cfg_t  cfg,
    // Current bus cycle
    input  wire pms_pkg::pms_isa_cyc_t cyc,
    // Decode result, active high
    output logic                       hit
);

    // Address compare with masked bits ignored
    wire addr_ok = ((cyc.addr ^ cfg.base) & ~cfg.mask) == 16'h0000;
    // Optional command qualification; either strobe counts
    wire cmd_ok  = !cfg.qual_cmd || cyc.rd || cyc.wr;

    // Address enable high marks a DMA cycle, so I/O decoding stays quiet
    assign hit = cfg.en && !cyc.aen && addr_ok && cmd_ok;

endmodule

`default_nettype wire

// ---- pms_board_model.sv ----
// Board-side master of the serial store port.
// Assumes the bench calls frame; the port stays quiet between frames.
`timescale 1ns/10ps
`default_nettype none

module pms_board_model
(
    // Clock
    input  wire logic core_clk,
    // Serial port
    output logic      ee_cs,
    output logic      ee_sk,
    output logic      ee_di,
    input  wire logic ee_do
);
    // Select low while unused, serial clock parked low
    initial
    begin
        ee_cs = 1'b0;
        ee_sk = 1'b0;
        ee_di = 1'b0;
    end

    // One command, MSB first; each bit spans five core cycles so that a
    // rise lands on a clean edge; returns the last 16 output bits seen
    task automatic frame(input logic [26:0] bits, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge core_clk);
        ee_cs <= 1'b1;
        for (int i = 26; i >= 0; i--)
        begin
            @(posedge core_clk);
            ee_di <= bits[i];
            @(posedge core_clk);
            ee_sk <= 1'b1;
            repeat (2) @(posedge core_clk);
            ee_sk <= 1'b0;
            @(posedge core_clk);
            #1;
            rd = {rd[14:0], ee_do};
        end
        @(posedge core_clk);
        ee_cs <= 1'b0;
        ee_di <= ~bits[0]; // Released line must not show a stale level
    endtask
endmodule
`default_nettype wire

// ---- pms_tb.sv ----
// Self-checking bench for the mode-dependent pin steering block.
// Assumes the board model drives the serial port; the bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
`include "pms_map.svh"

module tb;
    // Design pins
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    pms_pkg::pms_cfg_t nv_cfg = '0;
    logic              nv_cfg_load = 1'b0;
    logic [11:0]       isa_addr = 12'h000;
    logic              io_rd_n = 1'b1;
    logic              io_wr_n = 1'b1;
    logic              addr_en = 1'b0;
    logic              board_dma_req_in = 1'b0;
    logic [1:0]        board_irq_in = 2'h0;
    logic [1:0]        host_dma_ack_n = 2'h3;
    logic [5:0]        irq_steer_out;
    logic [1:0]        host_dma_req;
    logic              board_dma_ack_n;
    logic [1:0]        prog_chip_sel_n;
    logic              ee_cs;
    logic              ee_sk;
    logic              ee_di;
    logic              ee_do;
    // Bookkeeping
    int                n_errors = 0;
    int                cmp_count = 0;
    int                cycles = 0;

    // 100 MHz stands in for the bus oscillator
    always #5 core_clk = ~core_clk;

    // Hang guard at 5000 cycles, far above the roughly 850 cycles the tests need
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    pnp_mode_pin_steering i_dut (.core_clk(core_clk), .nrst(nrst), .nv_cfg(nv_cfg),
        .nv_cfg_load(nv_cfg_load), .isa_addr(isa_addr), .io_rd_n(io_rd_n),
        .io_wr_n(io_wr_n), .addr_en(addr_en), .board_dma_req_in(board_dma_req_in),
        .board_irq_in(board_irq_in), .host_dma_ack_n(host_dma_ack_n),
        .irq_steer_out(irq_steer_out), .host_dma_req(host_dma_req),
        .board_dma_ack_n(board_dma_ack_n), .prog_chip_sel_n(prog_chip_sel_n),
        .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));

    pms_board_model i_brd (.core_clk(core_clk), .ee_cs(ee_cs), .ee_sk(ee_sk),
        .ee_di(ee_di), .ee_do(ee_do));

    // Shared compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Wait until registered outputs have followed the inputs
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // Configuration arrives only as a stored word with a load strobe
    task automatic load(input pms_pkg::pms_cfg_t c);
        @(posedge core_clk);
        nv_cfg <= c;
        nv_cfg_load <= 1'b1;
        @(posedge core_clk);
        nv_cfg_load <= 1'b0;
    endtask

    // Drive every steering input in one go
    task automatic drv(input logic [11:0] a, input logic rd, input logic wr,
                       input logic aen, input logic req, input logic [1:0] irq,
                       input logic [1:0] ack);
        @(posedge core_clk);
        isa_addr <= a;
        io_rd_n <= rd;
        io_wr_n <= wr;
        addr_en <= aen;
        board_dma_req_in <= req;
        board_irq_in <= irq;
        host_dma_ack_n <= ack;
        settle();
    endtask

    task automatic chk_rst;
        chk(16'(irq_steer_out), 16'h0000);
        chk(16'(host_dma_req), 16'h0000);
        chk(16'(board_dma_ack_n), 16'h0001);
        chk(16'(prog_chip_sel_n), 16'h0003);
        chk(16'(ee_do), 16'h0000);
    endtask

    task automatic t_irq_route;
        pms_pkg::pms_cfg_t c;
        for (int ch = 0; ch < 2; ch++)
        begin
            for (int ln = 0; ln < 6; ln++)
            begin
                c = '0;
                c.irq[ch].en = 1'b1;
                c.irq[ch].line = 3'(ln);
                load(c);
                drv(12'h000, 1'b1, 1'b1, 1'b0, 1'b0, 2'(1 << ch), 2'h3);
                chk(16'(irq_steer_out), 16'(1 << ln));
            end
        end
        $display("test irq_route done");
    endtask

    task automatic t_dma;
        pms_pkg::pms_cfg_t c;
        for (int ch = 0; ch < 2; ch++)
        begin
            c = '0;
            c.dma_en = 1'b1;
            c.dma_chan = ch[0];
            load(c);
            drv(12'h000, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 2'(~(1 << (1 - ch))));
            chk(16'(host_dma_req), 16'(1 << ch));
            chk(16'(board_dma_ack_n), 16'h0001);
            drv(12'h000, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 2'(~(1 << ch)));
            chk(16'(board_dma_ack_n), 16'h0000);
        end
        $display("test dma done");
    endtask

    task automatic cs_step(input logic [11:0] a, input logic rd, input logic wr,
                           input logic aen, input logic [1:0] exp);
        drv(a, rd, wr, aen, 1'b0, 2'h0, 2'h3);
        chk(16'(prog_chip_sel_n), 16'(exp));
    endtask

    task automatic t_cs;
        pms_pkg::pms_cfg_t c;
        c = '0;
        c.cs[0] = {1'b1, 1'b0, 16'h0300, 16'h0007};
        c.cs[1] = {1'b1, 1'b1, 16'h0310, 16'h0000};
        load(c);
        cs_step(12'h305, 1'b1, 1'b1, 1'b0, 2'h2);
        cs_step(12'h305, 1'b1, 1'b1, 1'b1, 2'h3);
        cs_step(12'h308, 1'b1, 1'b1, 1'b0, 2'h3);
        cs_step(12'h310, 1'b1, 1'b1, 1'b0, 2'h3);
        cs_step(12'h310, 1'b0, 1'b1, 1'b0, 2'h1);
        cs_step(12'h310, 1'b1, 1'b0, 1'b0, 2'h1);
        cs_step(12'h307, 1'b0, 1'b1, 1'b0, 2'h2);
        $display("test chip_select done");
    endtask

    // Address 0xe123 is built from the borrowed pins in extended mode
    task automatic t_ext;
        pms_pkg::pms_cfg_t c;
        c = '0;
        c.mode = `PMS_MODE_EXT;
        c.irq[0] = {1'b1, 3'h6};
        c.irq[1] = {1'b1, 3'h7};
        c.dma_en = 1'b1;
        c.cs[2] = {1'b1, 1'b0, 16'he123, 16'h0000};
        load(c);
        drv(12'h123, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3, 2'h2);
        chk(16'(host_dma_req), 16'h0001);
        chk(16'(irq_steer_out), 16'h0000);
        chk(16'(board_dma_ack_n), 16'h0000);
        drv(12'h123, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3, 2'h1);
        chk(16'(board_dma_ack_n), 16'h0001);
        drv(12'h123, 1'b1, 1'b1, 1'b0, 1'b1, 2'h2, 2'h2);
        chk(16'(host_dma_req), 16'h0000);
        $display("test ext_mode done");
    endtask

    task automatic t_reserved;
        pms_pkg::pms_cfg_t c;
        for (int m = 2; m < 4; m++)
        begin
            c = '0;
            c.mode = 2'(m);
            c.dma_en = 1'b1;
            c.dma_chan = 1'b1;
            c.irq[0] = {1'b1, 3'h6};
            c.irq[1] = {1'b1, 3'h2};
            load(c);
            drv(12'h000, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3, 2'h3);
            chk(16'(host_dma_req), 16'h0002);
            chk(16'(irq_steer_out), 16'h0004);
        end
        $display("test reserved_mode done");
    endtask

    task automatic t_serial;
        logic [15:0] rd;
        i_brd.frame({1'b1, `PMS_OP_WRITE, 8'h5a, 16'hc3a5}, rd);
        i_brd.frame({1'b1, `PMS_OP_WRITE, 8'h5b, 16'h0ff0}, rd);
        // Unknown opcode must neither drive data out nor touch the store
        i_brd.frame({1'b1, 2'h3, 8'h5a, 16'h0000}, rd);
        chk(rd, 16'h0000);
        i_brd.frame({1'b1, `PMS_OP_READ, 8'h5a, 16'h0000}, rd);
        chk(rd, 16'hc3a5);
        i_brd.frame({1'b1, `PMS_OP_READ, 8'h5b, 16'h0000}, rd);
        chk(rd, 16'h0ff0);
        settle();
        chk(16'(ee_do), 16'h0000);
        $display("test serial done");
    endtask

    // Reset in mid-run must clear pins at once and drop the configuration
    task automatic t_reset;
        pms_pkg::pms_cfg_t c;
        c = '0;
        c.irq[0] = {1'b1, 3'h1};
        load(c);
        drv(12'h000, 1'b1, 1'b1, 1'b0, 1'b0, 2'h1, 2'h3);
        chk(16'(irq_steer_out), 16'h0002);
        @(posedge core_clk);
        nrst <= 1'b0;
        #2;
        chk_rst();
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        settle();
        chk(16'(irq_steer_out), 16'h0000);
        $display("test reset done");
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        @(posedge core_clk);
        #1;
        chk_rst();
        @(posedge core_clk);
        nrst <= 1'b1;
        t_irq_route();
        t_dma();
        t_cs();
        t_ext();
        t_reserved();
        t_serial();
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
